// file: rtl/tre_rx_ctrl_status.sv
// Receive control and latched status registers of one framer port
//
// The implementer's own choice: register access over AXI4-Lite.
module tre_rx_ctrl_status
	import tre_pkg::*;
#(
	parameter logic [2:0] PORT_INDEX = 3'h0
) (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic [tre_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]               s_axi_awprot,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [tre_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [tre_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]               s_axi_arprot,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [tre_pkg::DATA_W-1:0]    s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	input  wire logic                     t1_mode,
	input  wire logic                     rx_line_clk,
	input  wire logic                     line_rx_pos,
	input  wire logic                     line_rx_neg,
	input  wire logic                     remote_alarm_cond,
	input  wire logic                     all_ones_cond,
	input  wire logic                     frame_loss_cond,
	input  wire logic                     fbit_slot,
	input  wire logic                     fs_slot,
	input  wire logic                     fbit_err,
	input  wire logic                     bipolar_violation,
	input  wire logic                     mf_out_of_sync,
	input  wire logic                     alignment_changed,
	input  wire logic                     b8zs_codeword,
	input  wire logic [2:0]               channel_bit_index,
	input  wire logic                     tx_data,
	input  wire logic                     tx_test_port_clock,
	output logic                          test_port_data_out,
	output logic                          test_port_clock_out,
	output logic                          path_violation_inc,
	output logic                          mf_counter_inc,
	output logic                          violation_counter_inc,
	output logic [5:0]                    fifo_watermark_bytes,
	output logic                          interleave_enable,
	output logic                          interleave_frame_mode,
	output logic [3:0]                    interleave_devices,
	output logic [2:0]                    bus_position,
	output logic [3:0]                    spare_length_bits,
	output logic                          signal_loss_cond,
	output logic                          alarm_status_pending
);
	// ============================================================
	// Address decode
	function automatic tre_reg_e decode(input logic [ADDR_W-1:0] a);
		if (a == tre_byte_addr(IDX_ERR, PORT_INDEX))        return REG_ERR;
		else if (a == tre_byte_addr(IDX_FIFO, PORT_INDEX))  return REG_FIFO;
		else if (a == tre_byte_addr(IDX_IBUS, PORT_INDEX))  return REG_IBUS;
		else if (a == tre_byte_addr(IDX_SPARE, PORT_INDEX)) return REG_SPARE;
		else if (a == tre_byte_addr(IDX_TPORT, PORT_INDEX)) return REG_TPORT;
		else if (a == tre_byte_addr(IDX_SUPP, PORT_INDEX))  return REG_SUPP;
		else if (a == tre_byte_addr(IDX_ALARM, PORT_INDEX)) return REG_ALARM;
		else if (a == tre_byte_addr(IDX_EVENT, PORT_INDEX)) return REG_EVENT;
		else                                                return REG_NONE;
	endfunction : decode

	// ============================================================
	// Line side synchronisation
	logic [16:0] sync_s;
	logic        lclk_s;
	logic        line_one_s;
	logic [2:0]  cond_s;
	logic        fslot_s;
	logic        fs_s;
	logic        ferr_s;
	logic        bpv_s;
	logic        mfoos_s;
	logic        align_s;
	logic        b8zs_s;
	logic [2:0]  bit_idx_s;
	logic        txd_s;
	logic        txclk_s;

	tre_sync #(.W(17)) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({rx_line_clk, line_rx_pos | line_rx_neg, remote_alarm_cond,
			all_ones_cond, frame_loss_cond, fbit_slot, fs_slot, fbit_err,
			bipolar_violation, mf_out_of_sync, alignment_changed, b8zs_codeword,
			channel_bit_index, tx_data, tx_test_port_clock}),
		.sync_out (sync_s)
	);

	assign {lclk_s, line_one_s, cond_s, fslot_s, fs_s, ferr_s, bpv_s, mfoos_s,
		align_s, b8zs_s, bit_idx_s, txd_s, txclk_s} = sync_s;

	logic lclk_prev_ff;
	logic bit_stb;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			lclk_prev_ff <= 1'b0;
		else
			lclk_prev_ff <= lclk_s;
	end
	assign bit_stb = lclk_s && !lclk_prev_ff;

	logic los_w;
	logic z8_w;
	logic z16_w;
	logic pdv_w;

	tre_zero_mon u_zmon (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.bit_stb    (bit_stb),
		.bit_one    (line_one_s),
		.los_ff     (los_w),
		.eight_ff   (z8_w),
		.sixteen_ff (z16_w),
		.density_ff (pdv_w)
	);

	// ============================================================
	// AXI4-Lite slave
	logic                aw_hold_ff;
	logic                w_hold_ff;
	logic [ADDR_W-1:0]   awaddr_ff;
	logic [7:0]          wbyte_ff;
	logic                wlane_ff;
	logic                aw_fire;
	logic                w_fire;
	logic                do_write;
	logic                nxt_bvalid;
	logic                nxt_aw_hold;
	logic                nxt_w_hold;
	logic                ar_fire;
	logic                nxt_rvalid;
	tre_reg_e            wsel;
	tre_reg_e            rsel;
	logic [7:0]          rval;

	assign aw_fire     = s_axi_awvalid && s_axi_awready;
	assign w_fire      = s_axi_wvalid && s_axi_wready;
	assign do_write    = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
	assign nxt_bvalid  = do_write || (s_axi_bvalid && !s_axi_bready);
	assign nxt_aw_hold = (aw_hold_ff && !do_write) || aw_fire;
	assign nxt_w_hold  = (w_hold_ff && !do_write) || w_fire;
	assign ar_fire     = s_axi_arvalid && s_axi_arready;
	assign nxt_rvalid  = ar_fire || (s_axi_rvalid && !s_axi_rready);
	assign wsel        = decode(awaddr_ff);
	assign rsel        = decode(s_axi_araddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff    <= 1'b0;
			w_hold_ff     <= 1'b0;
			awaddr_ff     <= '0;
			wbyte_ff      <= 8'h00;
			wlane_ff      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			aw_hold_ff    <= nxt_aw_hold;
			w_hold_ff     <= nxt_w_hold;
			s_axi_awready <= !nxt_aw_hold && !nxt_bvalid;
			s_axi_wready  <= !nxt_w_hold && !nxt_bvalid;
			s_axi_bvalid  <= nxt_bvalid;
			if (aw_fire)
				awaddr_ff <= s_axi_awaddr;
			if (w_fire) begin
				wbyte_ff <= s_axi_wdata[7:0];
				wlane_ff <= s_axi_wstrb[0];
			end
			if (do_write)
				s_axi_bresp <= (wsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
		end
	end

	// Only byte lane 0 carries register data; other lanes are ignored
	logic       wr_en;
	assign wr_en = do_write && wlane_ff;

	// ============================================================
	// Control registers
	logic [7:0] err_ctrl_ff;
	logic [7:0] fifo_ctrl_ff;
	logic [7:0] ibus_ctrl_ff;
	logic [7:0] spare_ctrl_ff;
	logic [7:0] tport_ctrl_ff;
	logic [7:0] suppress_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_ctrl_ff   <= RST_CTRL;
			fifo_ctrl_ff  <= RST_CTRL;
			ibus_ctrl_ff  <= RST_CTRL;
			spare_ctrl_ff <= RST_CTRL;
			tport_ctrl_ff <= RST_CTRL;
			suppress_ff   <= RST_CTRL;
		end else if (wr_en) begin
			case (wsel)
				REG_ERR:   err_ctrl_ff   <= wbyte_ff & MASK_ERR;
				REG_FIFO:  fifo_ctrl_ff  <= wbyte_ff & MASK_FIFO;
				REG_IBUS:  ibus_ctrl_ff  <= wbyte_ff & MASK_IBUS;
				// Upper spare bits are expected zero; they are not stored
				REG_SPARE: spare_ctrl_ff <= wbyte_ff & MASK_SPARE;
				REG_TPORT: tport_ctrl_ff <= wbyte_ff & MASK_TPORT;
				REG_SUPP:  suppress_ff   <= wbyte_ff & MASK_SUPP;
				default: ;
			endcase
		end
	end

	// ============================================================
	// Latched status
	logic [7:0] alarm_ff;
	logic [7:0] event_ff;
	logic [3:0] cond_prev_ff;
	logic [3:0] cond_now;
	logic [7:0] alarm_set;
	logic [7:0] event_set;
	logic [7:0] alarm_clr;
	logic [7:0] event_clr;
	logic [5:0] sef_win_ff;
	logic [5:0] sef_next;
	logic       ft_err;

	assign cond_now  = {cond_s[2], cond_s[1], los_w, cond_s[0]};
	assign alarm_set = {cond_prev_ff & ~cond_now,
		~cond_prev_ff & cond_now};
	assign ft_err    = bit_stb && fslot_s && !fs_s && ferr_s;
	assign sef_next  = {sef_win_ff[4:0], ferr_s};

	always_comb begin
		event_set          = 8'h00;
		event_set[EV_PDV]  = pdv_w;
		event_set[EV_ALIGN] = bit_stb && align_s;
		event_set[EV_Z8]   = z8_w;
		event_set[EV_Z16]  = z16_w;
		event_set[EV_SEF]  = ft_err && $countones(sef_next) >= SEF_MIN_ERR;
		event_set[EV_B8ZS] = bit_stb && b8zs_s;
		event_set[EV_FBE]  = ft_err;
		if (!t1_mode)
			event_set = 8'h00;
	end

	assign alarm_clr = (wr_en && wsel == REG_ALARM) ? wbyte_ff : 8'h00;
	assign event_clr = (wr_en && wsel == REG_EVENT) ? wbyte_ff : 8'h00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cond_prev_ff <= 4'h0;
			sef_win_ff   <= 6'h00;
		end else begin
			cond_prev_ff <= cond_now;
			if (bit_stb && fslot_s && !fs_s)
				sef_win_ff <= sef_next;
		end
	end

	// Set wins over a clear written in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_ff <= 8'h00;
			event_ff <= 8'h00;
		end else begin
			alarm_ff <= (alarm_ff & ~alarm_clr) | alarm_set;
			event_ff <= ((event_ff & ~event_clr) | event_set) & MASK_EVENT;
		end
	end

	// Alarm flags feed the port's pending line; event flags never do
	always_ff @(posedge aclk) begin
		if (!aresetn)
			alarm_status_pending <= 1'b0;
		else
			alarm_status_pending <= |alarm_ff;
	end

	// ============================================================
	// Read path
	always_comb begin
		case (rsel)
			REG_ERR:   rval = err_ctrl_ff;
			REG_FIFO:  rval = fifo_ctrl_ff;
			REG_IBUS:  rval = ibus_ctrl_ff;
			REG_SPARE: rval = spare_ctrl_ff;
			REG_TPORT: rval = tport_ctrl_ff;
			REG_SUPP:  rval = suppress_ff;
			REG_ALARM: rval = alarm_ff;
			REG_EVENT: rval = event_ff;
			default:   rval = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !nxt_rvalid;
			s_axi_rvalid  <= nxt_rvalid;
			if (ar_fire) begin
				s_axi_rdata <= {24'h000000, rval};
				s_axi_rresp <= (rsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	// ============================================================
	// Counter event strobes for the error counters
	logic frm_err_cnt;
	assign frm_err_cnt = bit_stb && fslot_s && ferr_s && (!fs_s || err_ctrl_ff[ERR_FS_REPORT]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			path_violation_inc    <= 1'b0;
			mf_counter_inc        <= 1'b0;
			violation_counter_inc <= 1'b0;
		end else begin
			path_violation_inc    <= t1_mode && frm_err_cnt;
			mf_counter_inc        <= t1_mode && (err_ctrl_ff[ERR_MF_FUNC] ?
				bit_stb && mfoos_s : ft_err);
			violation_counter_inc <= (bit_stb && bpv_s) ||
				(err_ctrl_ff[ERR_VIOL_FUNC] && z8_w);
		end
	end

	// ============================================================
	// Test port
	logic rx_allow_ff;
	logic rx_bit_ff;
	logic tp_en;
	logic tp_dir;

	assign tp_en  = tport_ctrl_ff[TP_EN];
	assign tp_dir = tport_ctrl_ff[TP_DIR];

	// Gate is decided at the line edge and held for the whole bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_allow_ff <= 1'b0;
			rx_bit_ff   <= 1'b0;
		end else if (bit_stb) begin
			rx_bit_ff   <= line_one_s;
			rx_allow_ff <= !suppress_ff[3'd7 - bit_idx_s] &&
				(!fslot_s || (t1_mode && tport_ctrl_ff[TP_UNFRAMED]));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			test_port_data_out  <= 1'b0;
			test_port_clock_out <= 1'b0;
		end else if (!tp_en) begin
			test_port_data_out  <= 1'b0;
			test_port_clock_out <= 1'b0;
		end else if (tp_dir) begin
			test_port_data_out  <= txd_s;
			test_port_clock_out <= txclk_s;
		end else begin
			test_port_data_out  <= rx_bit_ff;
			test_port_clock_out <= lclk_s && rx_allow_ff;
		end
	end

	// ============================================================
	// Configuration outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fifo_watermark_bytes  <= 6'd4;
			interleave_enable     <= 1'b0;
			interleave_frame_mode <= 1'b0;
			interleave_devices    <= 4'd2;
			bus_position          <= 3'h0;
			spare_length_bits     <= 4'd1;
			signal_loss_cond      <= 1'b0;
		end else begin
			fifo_watermark_bytes  <= tre_watermark(fifo_ctrl_ff[1:0]);
			interleave_enable     <= ibus_ctrl_ff[IB_EN];
			interleave_frame_mode <= ibus_ctrl_ff[IB_EN] && ibus_ctrl_ff[IB_KIND];
			interleave_devices    <= tre_bus_devices(ibus_ctrl_ff[IB_SIZE_LSB +: 2]);
			bus_position          <= ibus_ctrl_ff[IB_POS_LSB +: 3];
			// Code 111 reads 8 and stands for the 8 or 16 bit length
			spare_length_bits     <= {1'b0, spare_ctrl_ff[2:0]} + 4'd1;
			signal_loss_cond      <= los_w;
		end
	end
endmodule : tre_rx_ctrl_status

// file: rtl/tre_pkg.sv
// Shared constants, register map and helpers for the receive control/status block
package tre_pkg;

	// ============================================================
	// Bus widths and answers
	localparam int          ADDR_W      = 16;
	localparam int          DATA_W      = 32;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ============================================================
	// Register indices; byte address is four times (index + port * PORT_STRIDE)
	localparam logic [13:0] PORT_STRIDE = 14'h0200;
	localparam logic [13:0] IDX_ERR     = 14'h0086;
	localparam logic [13:0] IDX_FIFO    = 14'h0087;
	localparam logic [13:0] IDX_IBUS    = 14'h0088;
	localparam logic [13:0] IDX_SPARE   = 14'h0089;
	localparam logic [13:0] IDX_TPORT   = 14'h008a;
	localparam logic [13:0] IDX_SUPP    = 14'h008b;
	localparam logic [13:0] IDX_ALARM   = 14'h0090;
	localparam logic [13:0] IDX_EVENT   = 14'h0091;

	// Reset values and writable bits
	localparam logic [7:0]  RST_CTRL    = 8'h00;
	localparam logic [7:0]  MASK_ERR    = 8'h07;
	localparam logic [7:0]  MASK_FIFO   = 8'h03;
	localparam logic [7:0]  MASK_IBUS   = 8'h7f;
	localparam logic [7:0]  MASK_SPARE  = 8'h07;
	localparam logic [7:0]  MASK_TPORT  = 8'h07;
	localparam logic [7:0]  MASK_SUPP   = 8'hff;
	localparam logic [7:0]  MASK_EVENT  = 8'hbf;

	// ============================================================
	// Field positions
	localparam int ERR_FS_REPORT = 2;
	localparam int ERR_MF_FUNC   = 1;
	localparam int ERR_VIOL_FUNC = 0;
	localparam int IB_SIZE_LSB   = 5;
	localparam int IB_KIND       = 4;
	localparam int IB_EN         = 3;
	localparam int IB_POS_LSB    = 0;
	localparam int TP_DIR        = 2;
	localparam int TP_UNFRAMED   = 1;
	localparam int TP_EN         = 0;
	localparam int EV_PDV        = 7;
	localparam int EV_ALIGN      = 5;
	localparam int EV_Z8         = 4;
	localparam int EV_Z16        = 3;
	localparam int EV_SEF        = 2;
	localparam int EV_B8ZS       = 1;
	localparam int EV_FBE        = 0;

	// ============================================================
	// Line monitor counts
	localparam logic [7:0]  LOS_ZEROS     = 8'd192;
	localparam logic [7:0]  EIGHT_ZEROS   = 8'd8;
	localparam logic [7:0]  SIXTEEN_ZEROS = 8'd16;
	localparam logic [7:0]  DENS_WINDOW   = 8'd192;
	localparam logic [7:0]  DENS_MIN_ONES = 8'd24;
	localparam int          SEF_MIN_ERR   = 2;

	typedef enum logic [3:0] {
		REG_NONE  = 4'h0,
		REG_ERR   = 4'h1,
		REG_FIFO  = 4'h2,
		REG_IBUS  = 4'h3,
		REG_SPARE = 4'h4,
		REG_TPORT = 4'h5,
		REG_SUPP  = 4'h6,
		REG_ALARM = 4'h7,
		REG_EVENT = 4'h8
	} tre_reg_e;

	function automatic logic [ADDR_W-1:0] tre_byte_addr(input logic [13:0] idx,
		input logic [2:0] port);
		logic [13:0] full;
		full = idx + PORT_STRIDE * {11'h000, port};
		return {full, 2'h0};
	endfunction : tre_byte_addr

	function automatic logic [5:0] tre_watermark(input logic [1:0] sel);
		case (sel)
			2'h0:    return 6'd4;
			2'h1:    return 6'd16;
			2'h2:    return 6'd32;
			default: return 6'd48;
		endcase
	endfunction : tre_watermark

	function automatic logic [3:0] tre_bus_devices(input logic [1:0] sel);
		case (sel)
			2'h0:    return 4'd2;
			2'h1:    return 4'd4;
			2'h2:    return 4'd8;
			default: return 4'd0;
		endcase
	endfunction : tre_bus_devices

endpackage : tre_pkg

// file: rtl/tre_sync.sv
// Two-flop synchroniser
module tre_sync #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff  <= '0;
			sync_out <= '0;
		end else begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule : tre_sync

// file: rtl/tre_zero_mon.sv
// Zero-run and pulse-density monitor on the received bit stream
module tre_zero_mon
	import tre_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic bit_stb,
	input  wire logic bit_one,
	output logic      los_ff,
	output logic      eight_ff,
	output logic      sixteen_ff,
	output logic      density_ff
);
	logic [7:0] zrun_ff;
	logic [7:0] win_ff;
	logic [7:0] ones_ff;

	// Run length saturates so a very long run still reads as long
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			zrun_ff <= 8'h00;
		end else if (bit_stb) begin
			if (bit_one)
				zrun_ff <= 8'h00;
			else if (zrun_ff != 8'hff)
				zrun_ff <= zrun_ff + 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			los_ff <= 1'b0;
		end else if (bit_stb) begin
			if (bit_one)
				los_ff <= 1'b0;
			else if (zrun_ff == LOS_ZEROS - 8'h01)
				los_ff <= 1'b1;
		end
	end

	// Pulses fire once when the run reaches the threshold
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eight_ff   <= 1'b0;
			sixteen_ff <= 1'b0;
		end else begin
			eight_ff   <= bit_stb && !bit_one && zrun_ff == EIGHT_ZEROS - 8'h01;
			sixteen_ff <= bit_stb && !bit_one && zrun_ff == SIXTEEN_ZEROS - 8'h01;
		end
	end

	// Density: more than fifteen zeros in a row, or too few ones in a block
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			win_ff     <= 8'h00;
			ones_ff    <= 8'h00;
			density_ff <= 1'b0;
		end else begin
			density_ff <= 1'b0;
			if (bit_stb) begin
				if (win_ff == DENS_WINDOW - 8'h01) begin
					win_ff     <= 8'h00;
					ones_ff    <= 8'h00;
					density_ff <= (ones_ff + {7'h00, bit_one}) < DENS_MIN_ONES;
				end else begin
					win_ff  <= win_ff + 8'h01;
					ones_ff <= ones_ff + {7'h00, bit_one};
				end
				if (!bit_one && zrun_ff == SIXTEEN_ZEROS - 8'h01)
					density_ff <= 1'b1;
			end
		end
	end
endmodule : tre_zero_mon

// file: testbench/tre_rx_checker.sv
// Port-level assertions
module tre_rx_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        t1_mode,
	input wire logic        path_violation_inc,
	input wire logic        mf_counter_inc,
	input wire logic [5:0]  fifo_watermark_bytes,
	input wire logic [3:0]  interleave_devices,
	input wire logic [3:0]  spare_length_bits
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ============================================================
	// Bus handshakes
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_b_timing: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	chk_r_timing: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read answer late");
	chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	// ============================================================
	// Decoded control levels and T1-only counter strobes
	chk_wm_codes: assert property (fifo_watermark_bytes inside {6'd4, 6'd16, 6'd32, 6'd48})
		else $error("bad watermark");
	chk_bus_sizes: assert property (interleave_devices inside {4'd0, 4'd2, 4'd4, 4'd8})
		else $error("bad bus size");
	chk_spare_len: assert property (spare_length_bits inside {[4'd1:4'd8]})
		else $error("bad spare length");
	chk_t1_counts: assert property (!t1_mode [*2] |-> !mf_counter_inc && !path_violation_inc)
		else $error("framing count outside T1");
endmodule : tre_rx_checker

bind tre_rx_ctrl_status tre_rx_checker u_chk (.*);

// file: testbench/tre_line_model.sv
// Line side source model
module tre_line_model (
	input  wire logic bit_one,
	output logic      rx_line_clk,
	output logic      line_rx_pos,
	output logic      line_rx_neg,
	output logic      fbit_slot,
	output logic      fs_slot,
	output logic      bipolar_violation,
	output logic      mf_out_of_sync,
	output logic      tx_data,
	output logic      tx_test_port_clock,
	output logic [2:0] channel_bit_index
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pol_ff = 1'b0;
	initial begin
		{rx_line_clk, line_rx_pos, line_rx_neg} = 3'h0;
		{fbit_slot, fs_slot, bipolar_violation, mf_out_of_sync} = 4'h0;
		{tx_data, tx_test_port_clock, channel_bit_index} = 5'h00;
		forever begin
			#80 rx_line_clk = 1'b1;
			#80 rx_line_clk = 1'b0;
			// Change on falling edge; stable at rising
			pol_ff = pol_ff ^ bit_one;
			line_rx_pos = bit_one & pol_ff;
			line_rx_neg = bit_one & !pol_ff;
			{fbit_slot, fs_slot, bipolar_violation, mf_out_of_sync} = 4'($urandom);
			{tx_data, tx_test_port_clock, channel_bit_index} = 5'($urandom);
		end
	end
endmodule : tre_line_model

// file: testbench/testbench.sv
// Self-checking bench
module testbench;
	import tre_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0, aresetn = 1'b0, t1_mode = 1'b0, bit_one = 1'b1;
	logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf, interleave_devices, spare_length_bits;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, fbit_err = 1'b0;
	logic        remote_alarm_cond = 1'b0, all_ones_cond = 1'b0, frame_loss_cond = 1'b0;
	logic        alignment_changed = 1'b0, b8zs_codeword = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        rx_line_clk, line_rx_pos, line_rx_neg, fbit_slot, fs_slot, bipolar_violation;
	logic        mf_out_of_sync, tx_data, tx_test_port_clock, test_port_data_out;
	logic        test_port_clock_out, path_violation_inc, mf_counter_inc, violation_counter_inc;
	logic        interleave_enable, interleave_frame_mode, signal_loss_cond, alarm_status_pending;
	logic [2:0]  channel_bit_index, bus_position;
	logic [5:0]  fifo_watermark_bytes;
	logic [33:0] rq [$], bq [$];
	logic [7:0]  v;
	logic [13:0] idx [8] = '{IDX_ERR, IDX_FIFO, IDX_IBUS, IDX_SPARE, IDX_TPORT, IDX_SUPP,
		IDX_ALARM, IDX_EVENT};
	int          n_fail = 0, n_tests = 0;
	tre_rx_ctrl_status #(.PORT_INDEX(3'h5)) dut (.*);
	tre_line_model u_line (.*);
	initial forever #10 aclk = ~aclk;
	// ============================================================
	// Tasks
	task automatic wrap_up();
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	function automatic logic [15:0] ad(input logic [13:0] i, input logic [2:0] p = 3'h5);
		return {i + 14'h0200 * p, 2'h0};
	endfunction : ad
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
		int n;
		@(posedge aclk);
		bq.push_back({32'h0, r});
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'($urandom), d};
		s_axi_awprot <= 3'($urandom);
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 100) n_fail++;
		if (n == 100) wrap_up();
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
		int n;
		@(posedge aclk);
		rq.push_back({r, 24'h0, d});
		s_axi_araddr <= a;
		s_axi_arprot <= 3'($urandom);
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 100) n_fail++;
		if (n == 100) wrap_up();
	endtask : rd
	// Oldest note against each result
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready) chk("bresp", bq.pop_front(), {32'h0, s_axi_bresp});
	end
	// ============================================================
	// Main sequence
	initial begin
		void'($urandom(32'h7cbb6d60));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		t1_mode <= 1'b1;
		chk("rst", 34'h421, {fifo_watermark_bytes, interleave_devices, spare_length_bits});
		foreach (idx[i]) begin
			rd(ad(idx[i]), 8'h00, RESP_OKAY);
			rd(ad(idx[i], 3'h0), 8'h00, RESP_SLVERR);
		end
		rd(ad(14'h008c), 8'h00, RESP_SLVERR);
		wr(ad(14'h008c), 8'hff, RESP_SLVERR);
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom);
			wr(ad(IDX_FIFO), {v[7:2], 2'(i)}, RESP_OKAY);
			wr(ad(IDX_IBUS), {v[7], 2'(i), v[4:3], 3'(i)}, RESP_OKAY);
			wr(ad(IDX_SPARE), {5'h00, 3'(i)}, RESP_OKAY);
			wr(ad(IDX_ERR), v, RESP_OKAY);
			wr(ad(IDX_SUPP), ~v, RESP_OKAY);
			wr(ad(IDX_TPORT), v & 8'hfe, RESP_OKAY);
			rd(ad(IDX_IBUS), {1'b0, 2'(i), v[4:3], 3'(i)}, RESP_OKAY);
			rd(ad(IDX_ERR), v & 8'h07, RESP_OKAY);
			rd(ad(IDX_SUPP), ~v, RESP_OKAY);
			rd(ad(IDX_TPORT), v & 8'h06, RESP_OKAY);
			chk("wm", (i % 4 == 0) ? 4 : 16 * (i % 4), fifo_watermark_bytes);
			chk("dev", (i % 4 == 3) ? 0 : 2 << (i % 4), interleave_devices);
			chk("pos", {v[4] & v[3], v[3], 3'(i)}, {interleave_frame_mode, interleave_enable, bus_position});
			chk("len", i + 1, spare_length_bits);
			chk("tport", 0, {test_port_data_out, test_port_clock_out});
		end
		// 191 zeros must not trip signal loss, 192 must
		bit_one <= 1'b0;
		@(negedge rx_line_clk);
		repeat (191) @(posedge rx_line_clk);
		repeat (6) @(posedge aclk);
		chk("los191", 0, signal_loss_cond);
		@(posedge rx_line_clk);
		repeat (7) @(posedge aclk);
		chk("los192", 3, {signal_loss_cond, alarm_status_pending});
		bit_one <= 1'b1;
		repeat (40) @(posedge aclk);
		rd(ad(IDX_ALARM), 8'h22, RESP_OKAY);
		rd(ad(IDX_EVENT), 8'h98, RESP_OKAY);
		wr(ad(IDX_ALARM), 8'hff, RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk("pend", 0, alarm_status_pending);
		wr(ad(IDX_EVENT), 8'h18, RESP_OKAY);
		rd(ad(IDX_EVENT), 8'h80, RESP_OKAY);
		{remote_alarm_cond, all_ones_cond, frame_loss_cond} <= 3'h7;
		repeat (10) @(posedge aclk);
		rd(ad(IDX_ALARM), 8'h0d, RESP_OKAY);
		{remote_alarm_cond, all_ones_cond, frame_loss_cond} <= 3'h0;
		repeat (10) @(posedge aclk);
		rd(ad(IDX_ALARM), 8'hdd, RESP_OKAY);
		repeat (4) @(posedge aclk);
		wrap_up();
	end
endmodule : testbench
